/* design/sfr_fifo.sv */
// Sample buffer storage and the readout register file.
// Assumes the sensing engine writes bytes with valid/ready and the host port is synchronous.
// Assumes the host reads the high level register before the flags register.
// Overflow is flagged when the engine offers a byte that the full buffer cannot take.
`timescale 1ns/1ps
`include "sfr_regs.svh"

// Byte store with valid/ready on both sides; a flush empties it in one cycle.
module sfr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic flush, // Empties the buffer
  input wire logic in_valid, // Write data offered
  output logic in_ready, // Space available
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic out_valid, // Data available
  input wire logic out_ready, // Pop request
  output logic [WIDTH-1:0] out_data, // Oldest entry
  output logic [$clog2(DEPTH+1)-1:0] level // Entry count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic rdy;
  } sfr_fifo_state_type;
  sfr_fifo_state_type s_r, s_nxt;
  logic push, pop;
  logic [DEPTH-1:0] wr_sel;

  // Pointers wrap by dropping the carry, so DEPTH must be a power of two
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    logic [AW:0] sum;
    sum = {1'b0, p} + {{AW{1'b0}}, 1'b1};
    ptr_inc = sum[AW-1:0];
  endfunction

  // Count moves by at most one either way per cycle
  function automatic logic [CW-1:0] cnt_next(input logic [CW-1:0] c,
    input logic up,
    input logic dn);
    cnt_next = c + CW'(up) - CW'(dn);
  endfunction

  // One select per entry keeps the write port a plain decoder
  for (genvar i = 0; i < DEPTH; i++) begin : g_sel
    assign wr_sel[i] = push && (s_r.wp == AW'(i));
  end

  // Ready is a flop of its own, taken from the next count, so it costs no latency
  assign in_ready = s_r.rdy;
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
  assign level = s_r.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_ready && out_valid;

  always_comb begin
    s_nxt = s_r;
    for (int i = 0; i < DEPTH; i++) begin
      if (wr_sel[i]) begin
        s_nxt.mem[i] = in_data;
      end
    end
    if (push) begin
      s_nxt.wp = ptr_inc(s_r.wp);
    end
    if (pop) begin
      s_nxt.rp = ptr_inc(s_r.rp);
    end
    s_nxt.cnt = cnt_next(s_r.cnt, push, pop);
    // Flush wins over a push or pop in the same cycle
    if (flush) begin
      s_nxt.wp = '0;
      s_nxt.rp = '0;
      s_nxt.cnt = '0;
    end
    s_nxt.rdy = (s_nxt.cnt != CW'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
      // Reset leaves the buffer empty, so ready starts high
      s_r.rdy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// Host register file in front of the buffer; reads answer one cycle after the strobe.
module sfr_readout
  import sfr_pkg::*;
(
  input wire logic clk, // System clock, 250 MHz
  input wire logic nrst, // Synchronous reset, active low
  input wire logic power_on_control, // Power-on bit; low clears the flags
  input wire logic buffer_clear_command, // One-cycle clear of buffer and flags
  input wire logic sample_valid, // Sensing engine offers a byte
  input wire logic [7:0] sample_data, // Sample byte
  output logic sample_ready, // Buffer accepts a byte
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  output logic [7:0] reg_rdata, // Read data, valid with reg_rvalid
  output logic reg_rvalid, // One-cycle read answer
  output logic buffer_interrupt // Level above threshold
);
  sfr_state_type s_r, s_nxt;
  logic [7:0] fifo_out;
  logic fifo_valid, fifo_pop, wr_fire;
  sfr_level_type buffer_fill_level;
  logic clr;
  logic sel_thr, sel_hi, sel_lo, sel_port;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Threshold holds level bits 8:1, so the bound is twice the register
  function automatic logic above_thr(input sfr_level_type lvl, input logic [7:0] thr);
    sfr_level_type bound;
    bound = {1'b0, thr, 1'b0};
    above_thr = (lvl > bound);
  endfunction

  function automatic logic [7:0] flags_byte(input logic ovf, input logic unf,
    input logic [1:0] low);
    flags_byte = {ovf, unf, 4'h0, low};
  endfunction

  assign sel_thr = hit(reg_addr, `SFR_OFS_THRESHOLD);
  assign sel_hi = hit(reg_addr, `SFR_OFS_LEVEL_HIGH);
  assign sel_lo = hit(reg_addr, `SFR_OFS_FLAGS_LOW);
  assign sel_port = hit(reg_addr, `SFR_OFS_READ_PORT);

  // Power-off also empties the buffer, so stale samples never survive it
  assign clr = buffer_clear_command || !power_on_control;
  assign fifo_pop = reg_rd && sel_port && fifo_valid;
  // Back-pressure reaches the engine; a byte offered while full is lost
  assign wr_fire = sample_valid && !sample_ready;

  sfr_fifo #(.WIDTH(8), .DEPTH(`SFR_DEPTH)) u_buf (
    .clk(clk),
    .nrst(nrst),
    .flush(clr),
    .in_valid(sample_valid && power_on_control),
    .in_ready(sample_ready),
    .in_data(sample_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out),
    .level(buffer_fill_level)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid_r = reg_rd;
    // Reads answer one cycle after the strobe, zero unless decoded
    s_nxt.rdata_r = 8'h00;
    if (reg_wr && sel_thr) begin
      s_nxt.threshold_r = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        `SFR_OFS_THRESHOLD: s_nxt.rdata_r = s_r.threshold_r;
        `SFR_OFS_LEVEL_HIGH: begin
          // Snapshot here so the flags byte matches the level just read
          s_nxt.rdata_r = buffer_fill_level[9:2];
          s_nxt.snap_low_r = buffer_fill_level[1:0];
          s_nxt.snap_ovf_r = s_r.overflow_r;
          s_nxt.snap_unf_r = s_r.underflow_r;
        end
        `SFR_OFS_FLAGS_LOW: begin
          // Snapshot only stays consistent if the high byte was read first
          s_nxt.rdata_r = flags_byte(s_r.snap_ovf_r, s_r.snap_unf_r, s_r.snap_low_r);
        end
        `SFR_OFS_READ_PORT: begin
          if (fifo_valid) begin
            s_nxt.rdata_r = fifo_out;
          end else begin
            s_nxt.rdata_r = 8'h00;
            s_nxt.underflow_r = 1'b1;
          end
        end
        default: s_nxt.rdata_r = 8'h00;
      endcase
    end
    if (wr_fire && power_on_control) begin
      s_nxt.overflow_r = 1'b1;
    end
    // A clear wins over a flag being set in the same cycle
    if (clr) begin
      s_nxt.overflow_r = 1'b0;
      s_nxt.underflow_r = 1'b0;
    end

    s_nxt.irq_r = above_thr(buffer_fill_level, s_r.threshold_r);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.threshold_r <= `SFR_THRESHOLD_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Every output below is a flop of the state
  assign reg_rdata = s_r.rdata_r;
  assign reg_rvalid = s_r.rvalid_r;
  assign buffer_interrupt = s_r.irq_r;
endmodule

/* design/sfr_regs.svh */
// Register offsets, field positions, reset values and sizes of the sample buffer readout.
// Assumes an internal register port with byte-wide data and an 8-bit address.
// Contract
// - Interrupt when level exceeds threshold times two
// - Buffer holds 512 bytes, ten-bit level
// - Level bits 9:2 and 1:0 split
// - Overflow flag at bit 7 on discard
// - Underflow flag at bit 6 on overread
// - Flags cleared only by power-on or clear
// - Data read pops oldest byte, level minus one
// - Empty read returns zero, sets underflow
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH
`define SFR_OFS_THRESHOLD 8'hfc
`define SFR_OFS_LEVEL_HIGH 8'hfd
`define SFR_OFS_FLAGS_LOW 8'hfe
`define SFR_OFS_READ_PORT 8'hff
`define SFR_THRESHOLD_RESET 8'h7f
`define SFR_DEPTH 512
`define SFR_LEVEL_W 10
`define SFR_BIT_OVERFLOW 7
`define SFR_BIT_UNDERFLOW 6
`endif

/* design/sfr_pkg.sv */
// Types shared by the sample buffer readout.
// Assumes sfr_regs.svh is on the include path.
`include "sfr_regs.svh"
package sfr_pkg;
  typedef logic [`SFR_LEVEL_W-1:0] sfr_level_type;
  typedef struct packed {
    logic [7:0] threshold_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic overflow_r;
    logic underflow_r;
    logic [1:0] snap_low_r;
    logic snap_ovf_r;
    logic snap_unf_r;
    logic irq_r;
  } sfr_state_type;
endpackage

/* tb/sfr_asserts.sv */
// Port checker for sfr_readout, attached by the bind at the foot; one clock.
`timescale 1ns/1ps
module sfr_asserts (
  input logic clk, // clock
  input logic nrst, // reset
  input logic power_on_control, // power
  input logic buffer_clear_command, // clear
  input logic reg_rd, // read
  input logic [7:0] reg_addr, // address
  input logic [7:0] reg_rdata, // data
  input logic reg_rvalid, // answer
  input logic buffer_interrupt // irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rd_answer: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
  a_no_stray: assert property (!reg_rd |=> !reg_rvalid) else $error("stray answer");
  a_unmapped_zero: assert property (reg_rd && reg_addr < 8'hfc |=> !reg_rdata)
    else $error("unmapped data");
  a_pad_zero: assert property (reg_rd && reg_addr == 8'hfe |=> !reg_rdata[5:2])
    else $error("pad bits");
  a_clr_level: assert property (buffer_clear_command ##2 reg_rd && reg_addr == 8'hfd
    |=> !reg_rdata) else $error("level kept");
  a_clr_flags: assert property (buffer_clear_command ##2 reg_rd && reg_addr == 8'hfd
    ##2 reg_rd && reg_addr == 8'hfe |=> !reg_rdata[7:6]) else $error("flags kept");
  a_clr_irq: assert property (buffer_clear_command |-> ##2 !buffer_interrupt)
    else $error("irq after clear");
  a_pon_quiet: assert property (!power_on_control [*3] |-> !buffer_interrupt)
    else $error("irq while off");
endmodule
bind sfr_readout sfr_asserts sfr_asserts_inst (.*);

/* tb/sfr_host.sv */
// Host model on the register port; each call starts after a falling edge.
`timescale 1ns/1ps
module sfr_host (
  input logic clk, // clock
  output logic reg_rd = 0, // read
  output logic reg_wr = 0, // write
  output logic [7:0] reg_addr = 0, // address
  output logic [7:0] reg_wdata = 0 // data
);
  task automatic acc(input logic w, input logic [7:0] a, wd);
    @(negedge clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, wd};
    @(negedge clk);
    {reg_wr, reg_rd} = 2'b00;
  endtask
endmodule

/* tb/sfr_readout_test.sv */
// Bench for sfr_readout; plays the sensing engine, reads through sfr_host.
`timescale 1ns/1ps
module sfr_readout_test;
  logic clk = 0, nrst = 0, power_on_control = 1, buffer_clear_command = 0, sample_valid = 0;
  logic sample_ready, reg_wr, reg_rd, reg_rvalid, buffer_interrupt;
  logic [7:0] sample_data = 0, reg_addr, reg_wdata, reg_rdata, q[$];
  int errors = 0, num_checks = 0, seed = 70;
  sfr_readout sfr_readout_inst (.*);
  sfr_host sfr_host_inst (.*);
  initial forever #2 clk = ~clk;
  task chk(input logic [9:0] got, exp);
    num_checks++;
    errors += got !== exp;
    if (got !== exp) $display("BAD %0t got %h want %h", $time, got, exp);
  endtask
  task conclude;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task r(input logic [7:0] a, e);
    sfr_host_inst.acc(0, a, 8'h00);
    chk(reg_rdata, e);
  endtask
  // The register holds threshold bits 8:1, so the bound in bytes is twice it
  function automatic logic exp_irq(input logic [9:0] n, input logic [7:0] thr);
    return n > {1'b0, thr, 1'b0};
  endfunction
  // Threshold is set to 5, so the interrupt wants more than 10 bytes
  task lvl(input logic [9:0] n, input logic [1:0] f);
    r(8'hfd, n[9:2]);
    r(8'hfe, {f, 4'h0, n[1:0]});
    chk(buffer_interrupt, exp_irq(n, 8'h05));
    chk(sample_ready, n != 10'd512);
  endtask
  // Mode 0 offers samples, 1 clears, 2 holds power off
  task push(input int n, input logic [1:0] m);
    repeat (n) begin
      @(negedge clk);
      {power_on_control, buffer_clear_command, sample_valid} = {m != 2, m == 1, m == 0};
      sample_data = 8'($random(seed));
      q.push_back(sample_data);
    end
    @(negedge clk);
    {power_on_control, buffer_clear_command, sample_valid} = 3'b100;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1;
    r(8'hfc, 8'h7f);
    r(8'h10, 8'h00);
    sfr_host_inst.acc(1, 8'hfc, 8'h05);
    r(8'hfc, 8'h05);
    push(10, 0);
    lvl(10, 0);
    while (q.size() > 0) r(8'hff, q.pop_front());
    r(8'hff, 8'h00);
    push(520, 0);
    lvl(512, 3);
    push(3, 2);
    lvl(0, 0);
    r(8'hff, 8'h00);
    push(1, 1);
    lvl(0, 0);
    conclude;
  end
endmodule
